/* File: core/pss_core.v */
// Stepper sequencer: static mode pins and an input clock become serial bursts for a power driver.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module pss_core
(
   // System clock, reset and clock enable.
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        ce,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Host pins.
   input  wire        step_clk_in,
   input  wire        counter_reset,
   input  wire        rotation_direction,
   input  wire        step_select_low,
   input  wire        step_select_high,
   input  wire        torque_boost_select,
   output reg         half_step_readback,
   // Power driver pins.
   output wire        ser_clk,
   output wire        ser_data_a,
   output wire        ser_data_b,
   output wire        ser_strobe
);
`include "pss_regs.vh"

   // Two-stage synchronisers for all six host pins.
   reg [5:0] pin_meta;
   reg [5:0] pin_sync;
   reg       clk_in_prev;

   // Pins sampled at each input clock edge while counter_reset is low.
   reg [1:0]  mode;
   reg        boost;
   reg        reset_pending;

   reg [`PSS_POS_W-1:0] pos;
   reg                  drive_en;
   reg                  start;
   reg [3:0]            word_a;
   reg [3:0]            word_b;

   wire       clk_in_s    = pin_sync[0];
   wire       cnt_reset_s = pin_sync[1];
   wire       dir_s       = pin_sync[2];
   wire [1:0] mode_s      = {pin_sync[3], pin_sync[4]};
   wire       boost_s     = pin_sync[5];
   wire       clk_edge    = clk_in_s & ~clk_in_prev;
   wire       ser_busy;

   reg [`PSS_POS_W-1:0] next_pos;
   reg [3:0]            next_word_a;
   reg [3:0]            next_word_b;

   // Ratio code of the sine of k eighth-steps within a quadrant, k = 0..8.
   function [2:0] ratio_code;
      input [3:0] k;
      begin
         if (k >= 4'h7)
            ratio_code = `PSS_CODE_MAX;
         else
            ratio_code = k[2:0];
      end
   endfunction

   // A burst is due when the position lies on the mode's output grid.
   function burst_due;
      input [1:0]            m;
      input [`PSS_POS_W-1:0] p;
      begin
         if (m == `PSS_MODE_FULL)
            burst_due = (p[2:0] == `PSS_HALF_STEP_PHASE);
         else if (m == `PSS_MODE_HALF)
            burst_due = (p[1:0] == 2'b00);
         else if (m == `PSS_MODE_QUARTER)
            burst_due = ~p[0];
         else
            burst_due = 1'b1;
      end
   endfunction

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin_meta    <= 6'h00;
         pin_sync    <= 6'h00;
         clk_in_prev <= 1'b0;
      end
      else if (ce)
      begin
         pin_meta    <= {torque_boost_select, step_select_high, step_select_low,
                         rotation_direction, counter_reset, step_clk_in};
         pin_sync    <= pin_meta;
         clk_in_prev <= clk_in_s;
      end
   end

   // Position moves one eighth-step per input clock edge in every mode.
   always @*
   begin
      if (dir_s)
         next_pos = pos - {{(`PSS_POS_W-1){1'b0}}, 1'b1};
      else
         next_pos = pos + {{(`PSS_POS_W-1){1'b0}}, 1'b1};
   end

   // Words for the position: polarity bit then ratio code for each phase.
   // The selects seen at this edge shape the word, so a new mode reaches the very next burst.
   always @*
   begin
      next_word_a = 4'h0;
      next_word_b = 4'h0;
      if (mode_s == `PSS_MODE_FULL)
      begin
         // Both phases on; boost lifts both from PSS_CODE_FULL to PSS_CODE_MAX.
         next_word_a = {next_pos[4] ^ next_pos[3], boost_s ? `PSS_CODE_MAX : `PSS_CODE_FULL};
         next_word_b = {next_pos[4], boost_s ? `PSS_CODE_MAX : `PSS_CODE_FULL};
      end
      else
      begin
         case (next_pos[4:3])
            2'b00:
            begin
               next_word_a = {1'b0, ratio_code(4'h8 - {1'b0, next_pos[2:0]})};
               next_word_b = {1'b0, ratio_code({1'b0, next_pos[2:0]})};
            end
            2'b01:
            begin
               next_word_a = {1'b1, ratio_code({1'b0, next_pos[2:0]})};
               next_word_b = {1'b0, ratio_code(4'h8 - {1'b0, next_pos[2:0]})};
            end
            2'b10:
            begin
               next_word_a = {1'b1, ratio_code(4'h8 - {1'b0, next_pos[2:0]})};
               next_word_b = {1'b1, ratio_code({1'b0, next_pos[2:0]})};
            end
            default:
            begin
               next_word_a = {1'b0, ratio_code({1'b0, next_pos[2:0]})};
               next_word_b = {1'b1, ratio_code(4'h8 - {1'b0, next_pos[2:0]})};
            end
         endcase
      end
   end

   // Sequencer: runs from the input clock alone, no host help per update.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode               <= `PSS_MODE_EIGHTH;
         boost              <= 1'b0;
         pos                <= {`PSS_POS_W{1'b0}};
         reset_pending      <= 1'b1;
         start              <= 1'b0;
         word_a             <= 4'h0;
         word_b             <= 4'h0;
         half_step_readback <= 1'b1;
      end
      else if (ce)
      begin
         start <= 1'b0;
         if (cnt_reset_s)
         begin
            // Counter held cleared; the next edge is spent on the reset.
            pos           <= {`PSS_POS_W{1'b0}};
            reset_pending <= 1'b1;
         end
         else if (clk_edge)
         begin
            // Selects are taken at every input clock edge while counter_reset is low.
            mode  <= mode_s;
            boost <= boost_s;
            if (reset_pending)
               reset_pending <= 1'b0;
            else
            begin
               pos                <= next_pos;
               half_step_readback <= (next_pos[2:0] != `PSS_HALF_STEP_PHASE);
               if (burst_due(mode_s, next_pos) && drive_en)
               begin
                  // Burst rate follows from the mode's grid.
                  start  <= 1'b1;
                  word_a <= next_word_a;
                  word_b <= next_word_b;
               end
            end
         end
      end
   end

   pss_serializer u_serializer
   (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .start      (start),
      .word_a     (word_a),
      .word_b     (word_b),
      .ser_clk    (ser_clk),
      .ser_data_a (ser_data_a),
      .ser_data_b (ser_data_b),
      .ser_strobe (ser_strobe),
      .busy       (ser_busy)
   );

   // APB slave: zero wait states, unmapped addresses answer with an error.
   wire apb_hit_ctrl = (paddr == `PSS_CTRL_ADDR);
   wire apb_hit_stat = (paddr == `PSS_STATUS_ADDR);
   wire apb_access   = psel & penable;

   localparam [31:0] CTRL_RESET = `PSS_CTRL_RESET;

   assign pready  = 1'b1;
   assign pslverr = apb_access & ~apb_hit_ctrl & ~apb_hit_stat;

   always @(posedge sys_clk)
   begin
      if (rst)
         drive_en <= CTRL_RESET[`PSS_CTRL_DRIVE_EN];
      else if (ce && apb_access && pwrite && apb_hit_ctrl)
         drive_en <= pwdata[`PSS_CTRL_DRIVE_EN];
   end

   always @*
   begin
      prdata = 32'h0000_0000;
      if (apb_hit_ctrl)
         prdata[`PSS_CTRL_DRIVE_EN] = drive_en;
      else if (apb_hit_stat)
      begin
         prdata[`PSS_STAT_POS_MSB:`PSS_STAT_POS_LSB]   = pos;
         prdata[`PSS_STAT_MODE_MSB:`PSS_STAT_MODE_LSB] = mode;
         prdata[`PSS_STAT_READBACK]                    = half_step_readback;
         prdata[`PSS_STAT_BUSY]                        = ser_busy;
         prdata[`PSS_STAT_BOOST]                       = boost;
      end
   end
endmodule // pss_core

/* File: core/pss_serializer.v */
// Serial burst generator: clock, two data lines and strobe towards the power driver.
`timescale 1ns/10ps
module pss_serializer
(
   // Clock and control.
   input  wire       sys_clk,
   input  wire       rst,
   input  wire       ce,
   // Burst request.
   input  wire       start,
   input  wire [3:0] word_a,
   input  wire [3:0] word_b,
   // Driver side.
   output reg        ser_clk,
   output reg        ser_data_a,
   output reg        ser_data_b,
   output reg        ser_strobe,
   output wire       busy
);
`include "pss_regs.vh"

   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_SHIFT  = 3'b010;
   localparam [2:0] ST_STROBE = 3'b100;

   reg [2:0] state;
   reg [2:0] phase;
   reg [3:0] shift_a;
   reg [3:0] shift_b;

   assign busy = (state != ST_IDLE);

   // Each bit takes two cycles: data set with clock low, then clock high.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state      <= ST_IDLE;
         phase      <= 3'h0;
         shift_a    <= 4'h0;
         shift_b    <= 4'h0;
         ser_clk    <= 1'b0;
         ser_data_a <= 1'b0;
         ser_data_b <= 1'b0;
         ser_strobe <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            ST_IDLE:
            begin
               ser_strobe <= 1'b0;
               ser_clk    <= 1'b0;
               if (start)
               begin
                  shift_a <= word_a;
                  shift_b <= word_b;
                  phase   <= 3'h0;
                  state   <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               phase <= phase + 3'h1;
               if (!phase[0])
               begin
                  ser_clk    <= 1'b0;
                  ser_data_a <= shift_a[3];
                  ser_data_b <= shift_b[3];
                  shift_a    <= {shift_a[2:0], 1'b0};
                  shift_b    <= {shift_b[2:0], 1'b0};
               end
               else
               begin
                  ser_clk <= 1'b1;
                  if (phase == 3'h7)
                     state <= ST_STROBE;
               end
            end
            ST_STROBE:
            begin
               ser_clk    <= 1'b0;
               ser_strobe <= 1'b1;
               state      <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule // pss_serializer

/* File: inc/pss_regs.vh */
// Register offsets, field positions, reset values, step modes and word codes of the stepper sequencer.
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// Register byte offsets.
`define PSS_CTRL_ADDR        12'h000
`define PSS_STATUS_ADDR      12'h004

// Control register fields and reset value.
`define PSS_CTRL_DRIVE_EN    0
`define PSS_CTRL_RESET       32'h0000_0001

// Status register fields.
`define PSS_STAT_POS_LSB     0
`define PSS_STAT_POS_MSB     4
`define PSS_STAT_MODE_LSB    5
`define PSS_STAT_MODE_MSB    6
`define PSS_STAT_READBACK    7
`define PSS_STAT_BUSY        8
`define PSS_STAT_BOOST       9

// Step modes, coded as {step_select_low, step_select_high}.
`define PSS_MODE_FULL        2'b00
`define PSS_MODE_QUARTER     2'b01
`define PSS_MODE_HALF        2'b10
`define PSS_MODE_EIGHTH      2'b11

// Position index: 8 eighth-steps per full step, 32 per electrical cycle.
`define PSS_POS_W            5
`define PSS_HALF_STEP_PHASE  3'h4

// Serial word: polarity bit and 3-bit current ratio code, sent MSB first.
`define PSS_WORD_W           4
`define PSS_CODE_MAX         3'h7
`define PSS_CODE_FULL        3'h4

`endif

/* File: test/pss_core_sva.sv */
// Concurrent checks on the stepper sequencer ports.
`timescale 1ns/10ps
module pss_core_sva
(
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins.
   input wire logic        half_step_readback,
   input wire logic        ser_clk,
   input wire logic        ser_strobe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rdy;
      psel && penable |-> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready low in access");
   property p_err;
      psel && penable && paddr != 12'h000 && paddr != 12'h004 |-> pslverr && (pwrite || prdata == 32'h0000_0000);
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_ok;
      psel && penable && (paddr == 12'h000 || paddr == 12'h004) |-> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_strb;
      $rose(ser_strobe) |=> !ser_strobe [*8];
   endproperty
   a_strb: assert property (p_strb) else $error("strobe too long or bursts too close");
   property p_sfall;
      $rose(ser_strobe) |-> $fell(ser_clk);
   endproperty
   a_sfall: assert property (p_sfall) else $error("strobe not after last clock");
   property p_clk;
      $rose(ser_clk) |=> !ser_clk;
   endproperty
   a_clk: assert property (p_clk) else $error("serial clock high too long");
   property p_rst;
      disable iff (1'b0) rst |=> !ser_clk && !ser_strobe && half_step_readback;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle in reset");
   property p_rb;
      $fell(half_step_readback) |=> !half_step_readback [*8];
   endproperty
   a_rb: assert property (p_rb) else $error("readback low too short");
endmodule // pss_core_sva
bind pss_core pss_core_sva u_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .half_step_readback(half_step_readback),
   .ser_clk(ser_clk), .ser_strobe(ser_strobe));

/* File: test/pss_core_tb.sv */
// Self-checking bench of the stepper sequencer.
`timescale 1ns/10ps
`include "pss_regs.vh"
module pss_core_tb;
   logic        sys_clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, go = 0, clk_q = 0;
   logic        counter_reset = 0, rotation_direction = 0, step_select_low = 1, step_select_high = 1;
   logic        torque_boost_select = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [7:0]  n_edges = 0;
   logic [3:0]  sh_a = 0, sh_b = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, half_step_readback, ser_clk, ser_data_a, ser_data_b, ser_strobe, step_clk_in, busy;
   int          n_strobe = 0, n_fail = 0, total_checks = 0, cyc = 0;
   logic [31:0] qr[$];
   logic [7:0]  qw[$];
   pss_core DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_clk_in(step_clk_in), .counter_reset(counter_reset), .rotation_direction(rotation_direction),
      .step_select_low(step_select_low), .step_select_high(step_select_high),
      .torque_boost_select(torque_boost_select), .half_step_readback(half_step_readback), .ser_clk(ser_clk),
      .ser_data_a(ser_data_a), .ser_data_b(ser_data_b), .ser_strobe(ser_strobe));
   pss_host_model HOST (.go(go), .n_edges(n_edges), .step_clk_in(step_clk_in), .busy(busy));
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   function logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task tally(input string name, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask
   task chk_count(input string name, input logic [31:0] e, input logic [31:0] g);
      tally(name, e, g);
   endtask
   task chk_word(input logic [7:0] e, input logic [7:0] g);
      tally("serial word", {24'h00_0000, e}, {24'h00_0000, g});
   endtask
   task chk_read(input logic [31:0] e, input logic [31:0] g);
      tally("read data", e, g);
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      if (!w) qr.push_back(e);
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
   endtask
   task pulse(input logic [7:0] n);
      @(posedge sys_clk);
      n_edges <= n; go <= 1;
      @(posedge sys_clk);
      go <= 0;
      @(posedge sys_clk);
      while (busy) @(posedge sys_clk);
   endtask
   task run(input logic [7:0] n, input int e);
      int s0;
      s0 = n_strobe;
      pulse(n);
      chk_count("burst count", e, n_strobe - s0);
   endtask
   // Pins change only once the readback reports a half-step position.
   task set_mode(input logic [3:0] m);
      repeat (8) if (half_step_readback !== 1'b0) pulse(1);
      {step_select_low, step_select_high, torque_boost_select, rotation_direction} <= m;
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      clk_q <= ser_clk;
      if (ser_strobe) n_strobe <= n_strobe + 1;
      if (ser_clk && !clk_q) {sh_a, sh_b} <= {sh_a[2:0], ser_data_a, sh_b[2:0], ser_data_b};
      if (ser_strobe && qw.size() > 0) chk_word(qw.pop_front(), {sh_a, sh_b});
      if (psel && penable && pready && !pwrite) chk_read(qr.pop_front(), prdata);
      if (cyc == 12000)
      begin
         n_fail++;
         results;
      end
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 0;
      apb(0, `PSS_CTRL_ADDR, 0, `PSS_CTRL_RESET);
      apb(1, 12'h008, lfsr(32'h514e), 0);
      apb(0, 12'h008, 0, 0);
      counter_reset <= 1;
      repeat (4) @(posedge sys_clk);
      counter_reset <= 0;
      repeat (4) @(posedge sys_clk);
      run(16, 15);
      set_mode(4'b0100);
      // Quarter steps from position 20: first bursts at positions 22 and 24.
      qw = {8'hAE, 8'h0F};
      run(16, 8);
      set_mode(4'b1000);
      run(16, 4);
      qw = {8'h4C, 8'h44};
      set_mode(4'b0000);
      run(16, 2);
      qw = {8'hF7, 8'hFF};
      set_mode(4'b0010);
      run(16, 2);
      set_mode(4'b1101);
      apb(1, `PSS_CTRL_ADDR, 0, 0);
      run(8, 0);
      apb(1, `PSS_CTRL_ADDR, 1, 0);
      run(8, 8);
      apb(0, `PSS_STATUS_ADDR, 0, 32'h0000_0064);
      // Clock enable low: an APB write must leave the control register alone.
      ce <= 0;
      apb(1, `PSS_CTRL_ADDR, 0, 0);
      ce <= 1;
      apb(0, `PSS_CTRL_ADDR, 0, 1);
      // Let the monitor take the last read before the queues are judged.
      @(posedge sys_clk);
      chk_count("pending notes", 0, qr.size() + qw.size());
      results;
   end
endmodule // pss_core_tb

/* File: test/pss_host_model.sv */
// Host model: gives a counted run of input clock edges, standing low between runs.
`timescale 1ns/10ps
module pss_host_model
(
   // Request.
   input  wire logic       go,
   input  wire logic [7:0] n_edges,
   // Pins.
   output logic            step_clk_in,
   output logic            busy
);
   initial
   begin
      step_clk_in = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge go);
         busy = 1'b1;
         #7.3;
         repeat (n_edges)
         begin
            #40 step_clk_in = 1'b1;
            #40 step_clk_in = 1'b0;
         end
         #200 busy = 1'b0;
      end
   end
endmodule // pss_host_model
